// >>> design/rob_pkg.sv
/*
  Package for the reset option byte decoder.
  Holds the option byte location, field positions and the crystal wait
  counts in precision oscillator cycles. Assumes one system clock.
*/
package rob_pkg;
  localparam logic [15:0] ROB_OPTION_ADDR = 16'h0001;
  localparam int ROB_WAIT_HI = 7;
  localparam int ROB_WAIT_LO = 6;
  localparam int ROB_GUARD_BIT = 5;
  localparam int ROB_XTAL1_BIT = 4;
  localparam int ROB_RSVD_HI = 3;
  localparam int ROB_RSVD_LO = 2;
  localparam int ROB_SRC2_BIT = 1;
  localparam int ROB_XTAL2_BIT = 0;
  localparam logic [13:0] ROB_WAIT_CYC0 = 14'd500;
  localparam logic [13:0] ROB_WAIT_CYC1 = 14'd1000;
  localparam logic [13:0] ROB_WAIT_CYC2 = 14'd5000;
  localparam logic [13:0] ROB_WAIT_CYC3 = 14'd10000;
  typedef enum logic [2:0] {
    ROB_IDLE, ROB_FETCH, ROB_WAIT_DATA, ROB_STABLE, ROB_RUN
  } rob_state_e;
endpackage

// >>> design/rob_reset_option_byte_decode.sv
/*
  Reset option byte decoder: fetches the option byte from flash while the
  device is held in reset, latches its fields, drives oscillator and write
  guard settings, and counts the crystal stabilisation wait.
  Assumes flash answers a read with rd_valid some cycles after rd_req,
  and that osc_tick_in is a one-cycle pulse per precision oscillator cycle
  already on sys_clk_in.
*/
`timescale 1ns/100ps

// Functional notes
// R1 - wait field picks 500, 1000, 5000 or 10000 precision oscillator cycles
// R2 - guard bit set blocks flash writes when low voltage detector trips
// R3 - primary crystal bit clear runs crystal during reset, set keeps it off
// R4 - primary bit affects reset state only; clock choice left to osc control
// R5 - source bit clear picks external clock, set picks 32kHz watch crystal
// R6 - secondary bit clear enables secondary crystal during reset, set disables
// R7 - option byte lives at 0001H; reset never forces a default into it
// R8 - fetch and latch byte before wait count or applying any setting
module rob_reset_option_byte_decode
  import rob_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic sys_reset_req_in, // reset request from sequencer
  input wire logic osc_tick_in, // precision oscillator cycle pulse
  input wire logic [7:0] flash_rd_data_in, // flash read data
  input wire logic flash_rd_valid_in, // flash read data valid
  input wire logic low_voltage_detector_in, // low voltage flag
  input wire logic flash_wr_req_in, // flash write request
  output logic [15:0] flash_rd_addr_out, // flash read address
  output logic flash_rd_req_out, // flash read request
  output logic [7:0] option_byte_out, // latched option byte
  output logic options_valid_out, // fields latched
  output logic primary_xtal_en_out, // primary crystal enable
  output logic secondary_xtal_en_out, // secondary crystal enable
  output logic secondary_osc_source_sel_out, // 1 watch crystal, 0 ext clk
  output logic flash_wr_allow_out, // flash write permitted
  output logic reset_release_out // reset sequence finished
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] wait_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: wait_cycles = ROB_WAIT_CYC0;
      2'h1: wait_cycles = ROB_WAIT_CYC1;
      2'h2: wait_cycles = ROB_WAIT_CYC2;
      default: wait_cycles = ROB_WAIT_CYC3;
    endcase
  endfunction

  rob_state_e state_reg;
  logic [7:0] reset_clock_option_byte_reg;
  logic valid_reg;
  logic [13:0] wait_cnt_reg;
  logic [1:0] crystal_reset_wait_sel;
  logic low_voltage_write_guard;
  logic primary_xtal_reset_state;
  logic secondary_osc_source_sel;
  logic secondary_xtal_reset_state;
  logic in_reset;
  logic low_voltage_meta_reg;
  logic low_voltage_sync_reg;

  assign crystal_reset_wait_sel =
    reset_clock_option_byte_reg[ROB_WAIT_HI:ROB_WAIT_LO];
  assign low_voltage_write_guard = reset_clock_option_byte_reg[ROB_GUARD_BIT];
  assign primary_xtal_reset_state =
    reset_clock_option_byte_reg[ROB_XTAL1_BIT];
  assign secondary_osc_source_sel = reset_clock_option_byte_reg[ROB_SRC2_BIT];
  assign secondary_xtal_reset_state =
    reset_clock_option_byte_reg[ROB_XTAL2_BIT];
  assign in_reset = (state_reg != ROB_RUN);

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_reg <= ROB_IDLE;
    else if (sys_reset_req_in)
      state_reg <= ROB_FETCH;
    else
    begin
      case (state_reg)
        ROB_IDLE: state_reg <= ROB_FETCH;
        ROB_FETCH: state_reg <= ROB_WAIT_DATA;
        ROB_WAIT_DATA:
          if (flash_rd_valid_in)
            state_reg <= ROB_STABLE; // R8
        ROB_STABLE:
          if (osc_tick_in && wait_cnt_reg == 14'h0001)
            state_reg <= ROB_RUN;
        ROB_RUN: state_reg <= ROB_RUN;
        default: state_reg <= ROB_IDLE;
      endcase
    end
  end

  // option byte copy: no reset value, only flash contents load it
  always_ff @(posedge sys_clk_in)
  begin
    if (state_reg == ROB_WAIT_DATA && flash_rd_valid_in)
      reset_clock_option_byte_reg <= flash_rd_data_in; // R7
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      valid_reg <= 1'b0;
    else if (state_reg == ROB_WAIT_DATA && flash_rd_valid_in)
      valid_reg <= 1'b1; // R8
    else if (state_reg == ROB_FETCH)
      valid_reg <= 1'b0;
  end

  // stabilisation wait counter
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wait_cnt_reg <= 14'h0000;
    else if (state_reg == ROB_WAIT_DATA && flash_rd_valid_in)
      wait_cnt_reg <= wait_cycles(
        flash_rd_data_in[ROB_WAIT_HI:ROB_WAIT_LO]); // R1
    else if (state_reg == ROB_STABLE && osc_tick_in)
      wait_cnt_reg <= wait_cnt_reg - 14'h0001; // R1
  end

  // detector output is asynchronous to the system clock
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      low_voltage_meta_reg <= 1'b0;
      low_voltage_sync_reg <= 1'b0;
    end
    else
    begin
      low_voltage_meta_reg <= low_voltage_detector_in;
      low_voltage_sync_reg <= low_voltage_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign flash_rd_addr_out = ROB_OPTION_ADDR; // R7
  assign flash_rd_req_out = (state_reg == ROB_FETCH);
  assign option_byte_out = valid_reg ? reset_clock_option_byte_reg : 8'h00;
  assign options_valid_out = valid_reg;
  assign reset_release_out = (state_reg == ROB_RUN);
  // outside reset both crystal enables are driven high; osc control owns clock choice
  assign primary_xtal_en_out = valid_reg &&
    (!in_reset || !primary_xtal_reset_state); // R3 R4
  assign secondary_xtal_en_out = valid_reg &&
    (!in_reset || !secondary_xtal_reset_state); // R6
  assign secondary_osc_source_sel_out = valid_reg &&
    secondary_osc_source_sel; // R5
  assign flash_wr_allow_out = valid_reg && !in_reset &&
    !(low_voltage_write_guard && low_voltage_sync_reg); // R2

  ////////////////////////////////////////////////////////////////////////
  AST_WAIT_LOAD: assert property (@(posedge sys_clk_in) // R1
    disable iff (!resetn_in)
    (state_reg == ROB_WAIT_DATA && flash_rd_valid_in && !sys_reset_req_in)
    |=> wait_cnt_reg == wait_cycles($past(flash_rd_data_in[7:6])))
    else $error("wait count not loaded from field");
  AST_GUARD: assert property (@(posedge sys_clk_in) // R2
    disable iff (!resetn_in)
    (low_voltage_write_guard && low_voltage_sync_reg)
    |-> !flash_wr_allow_out)
    else $error("flash write allowed under low voltage guard");
  AST_NO_GUARD: assert property (@(posedge sys_clk_in) // R2
    disable iff (!resetn_in)
    (valid_reg && !in_reset && !low_voltage_write_guard)
    |-> flash_wr_allow_out)
    else $error("flash write blocked with guard off");
  AST_XTAL1: assert property (@(posedge sys_clk_in) // R3
    disable iff (!resetn_in)
    (valid_reg && in_reset) |->
    primary_xtal_en_out == !primary_xtal_reset_state)
    else $error("primary crystal reset state wrong");
  AST_XTAL1_RUN: assert property (@(posedge sys_clk_in) // R4
    disable iff (!resetn_in)
    (valid_reg && !in_reset) |-> primary_xtal_en_out)
    else $error("primary crystal changed outside reset");
  AST_SRC2: assert property (@(posedge sys_clk_in) // R5
    disable iff (!resetn_in)
    valid_reg |-> secondary_osc_source_sel_out == option_byte_out[1])
    else $error("secondary source select wrong");
  AST_XTAL2: assert property (@(posedge sys_clk_in) // R6
    disable iff (!resetn_in)
    (valid_reg && in_reset) |->
    secondary_xtal_en_out == !option_byte_out[0])
    else $error("secondary crystal reset state wrong");
  AST_ADDR: assert property (@(posedge sys_clk_in) // R7
    disable iff (!resetn_in)
    flash_rd_req_out |-> flash_rd_addr_out == 16'h0001)
    else $error("option byte fetched from wrong address");
  AST_ORDER: assert property (@(posedge sys_clk_in) // R8
    disable iff (!resetn_in)
    !valid_reg |-> !reset_release_out && !flash_wr_allow_out &&
    !primary_xtal_en_out && !secondary_xtal_en_out)
    else $error("setting applied before byte latched");
  AST_TICK_HOLD: assert property (@(posedge sys_clk_in) // R1
    disable iff (!resetn_in)
    (state_reg == ROB_STABLE && !osc_tick_in) |=> $stable(wait_cnt_reg))
    else $error("wait count moved without a tick");
  AST_WAIT_DONE: assert property (@(posedge sys_clk_in) // R1
    disable iff (!resetn_in)
    (state_reg == ROB_STABLE && osc_tick_in && wait_cnt_reg == 14'h0001 &&
    !sys_reset_req_in) |=> reset_release_out)
    else $error("reset not released after last tick");
  AST_NO_EARLY: assert property (@(posedge sys_clk_in) // R1
    disable iff (!resetn_in)
    (state_reg == ROB_STABLE && !(osc_tick_in && wait_cnt_reg == 14'h0001))
    |=> !reset_release_out)
    else $error("reset released before wait ended");
  AST_KEEP: assert property (@(posedge sys_clk_in) // R7
    disable iff (!resetn_in)
    (valid_reg && !(state_reg == ROB_WAIT_DATA && flash_rd_valid_in))
    |=> $stable(reset_clock_option_byte_reg))
    else $error("option byte changed without a fetch");

  COV_FETCH: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
    flash_rd_req_out ##[1:20] options_valid_out);
  COV_RELEASE: cover property (@(posedge sys_clk_in)
    disable iff (!resetn_in) $rose(reset_release_out));
  COV_GUARD: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
    flash_wr_req_in && !flash_wr_allow_out && reset_release_out);
  COV_REFETCH: cover property (@(posedge sys_clk_in)
    disable iff (!resetn_in) reset_release_out && sys_reset_req_in);
  COV_LONG_WAIT: cover property (@(posedge sys_clk_in)
    disable iff (!resetn_in) options_valid_out && option_byte_out[7:6] == 2'h3);

endmodule

// >>> bench/rob_flash_model.sv
/*
  Flash option storage model for the option byte decoder bench.
  Assumes one read request pulse per fetch, on the system clock.
*/
`timescale 1ns/100ps
module rob_flash_model (
  input wire logic clk_in, // system clock
  input wire logic req_in, // read request pulse
  input wire logic [15:0] addr_in, // read address
  input wire logic [7:0] byte_in, // stored option byte
  input wire logic [3:0] dly_in, // answer delay in cycles
  output logic [7:0] data_out, // read data
  output logic valid_out // read data valid pulse
);
  int cnt = -1;
  logic [7:0] last = 8'h00;
  always @(posedge clk_in)
  begin
    valid_out <= 1'b0;
    // released bus shows no stale value
    data_out <= ~last;
    if (req_in)
      cnt <= dly_in;
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0)
    begin
      cnt <= -1;
      valid_out <= 1'b1;
      data_out <= (addr_in == 16'h0001) ? byte_in : ~byte_in;
      last <= byte_in;
    end
  end
endmodule

// >>> bench/rob_reset_option_byte_decode_tb.sv
/*
  Self-checking bench for the option byte decoder.
  Drives random oscillator ticks and counts them against the wait field.
*/
`timescale 1ns/100ps
module rob_reset_option_byte_decode_tb;
  import rob_pkg::*;
  logic sys_clk_in = 0, resetn_in = 0, req = 0, low_volt = 0, wr = 0;
  logic tick = 0;
  logic [7:0] fbyte = 8'h00, b, rdata, ob;
  logic [3:0] dly = 4'h0;
  logic [15:0] addr;
  logic rreq, valid, ov, px, sx, src, allow, rel;
  int miscompares = 0, n_tests = 0, seed = 58574, cnt, ticks;
  int waits[4] = '{500, 1000, 5000, 10000};
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
    tick <= ($random(seed) & 3) != 0;
  rob_reset_option_byte_decode u_rob_reset_option_byte_decode (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .sys_reset_req_in(req), .osc_tick_in(tick),
    .flash_rd_data_in(rdata), .flash_rd_valid_in(valid),
    .low_voltage_detector_in(low_volt), .flash_wr_req_in(wr),
    .flash_rd_addr_out(addr), .flash_rd_req_out(rreq),
    .option_byte_out(ob), .options_valid_out(ov),
    .primary_xtal_en_out(px), .secondary_xtal_en_out(sx),
    .secondary_osc_source_sel_out(src), .flash_wr_allow_out(allow),
    .reset_release_out(rel));
  rob_flash_model u_rob_flash_model (.clk_in(sys_clk_in), .req_in(rreq),
    .addr_in(addr), .byte_in(fbyte), .dly_in(dly), .data_out(rdata),
    .valid_out(valid));
  //////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      b = {i[1:0], i[0], i[1], 2'h0, 2'($random(seed))};
      fbyte <= b;
      dly <= 4'($random(seed));
      if (i > 0)
      begin
        @(posedge sys_clk_in);
        req <= 1'b1;
        @(posedge sys_clk_in);
        req <= 1'b0;
      end
      cnt = 0;
      @(negedge sys_clk_in);
      // a refetch first hides the settings of the last byte
      while (ov === 1'b1 && cnt < 100)
      begin
        @(negedge sys_clk_in);
        cnt++;
      end
      while (ov !== 1'b1 && cnt < 100)
      begin
        @(negedge sys_clk_in);
        cnt++;
      end
      if (cnt >= 100)
      begin
        miscompares++;
        print_verdict;
      end
      check(16'(ob), 16'(b));
      check(16'(px), 16'(!b[4]));
      check(16'(sx), 16'(!b[0]));
      check(16'(src), 16'(b[1]));
      cnt = 0;
      ticks = 0;
      while (rel !== 1'b1 && cnt < 20000)
      begin
        if (tick === 1'b1)
          ticks++;
        @(negedge sys_clk_in);
        cnt++;
      end
      check(16'(ticks), 16'(waits[i]));
      if (cnt >= 20000)
      begin
        miscompares++;
        print_verdict;
      end
      for (int j = 0; j < 4; j++)
      begin
        @(posedge sys_clk_in);
        low_volt <= j[0];
        wr <= 1'($random(seed));
        // detector passes two synchroniser stages
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check(16'(allow), 16'(!(b[5] && j[0])));
        check(16'(px), 16'h0001);
      end
    end
    print_verdict;
  end
endmodule
